//--- hw/rxwk_regs.svh
// Register indices, reset values and field limits of the config bank
`ifndef RXWK_REGS_SVH
`define RXWK_REGS_SVH
// Register indices; byte address is four times the index
`define RXWK_IDX_IF    8'h16
`define RXWK_IDX_WUC   8'h17
`define RXWK_IDX_CNT   8'h1A
`define RXWK_IDX_CHCFG 8'h20
`define RXWK_IDX_STAT  8'h21
`define RXWK_IDX_MASK  8'h22
`define RXWK_IDX_EFF   8'h23
// Reset values
`define RXWK_RST_IF    7'h20
`define RXWK_RST_WUC   7'h04
`define RXWK_RST_CNT   7'h00
`define RXWK_RST_CHCFG 4'h0
`define RXWK_RST_STAT  3'h0
`define RXWK_RST_MASK  3'h0
// Highest legal codes
`define RXWK_BW_MAX    3'h4
`define RXWK_CRIT_MAX  3'h5
// External processing field values
`define RXWK_XP_SYNC   2'h1
`define RXWK_XP_RSSI   2'h2
// Search modes
`define RXWK_SM_COO    2'h0
`define RXWK_SM_FFB    2'h1
`define RXWK_SM_PWS    2'h2
// Status bit positions
`define RXWK_ST_BW     0
`define RXWK_ST_CRIT   1
`define RXWK_ST_REMAP  2
// Bus constants
`define RXWK_HSIZE_WORD 3'h2
`endif

//--- hw/rxwk_pkg.sv
// Types shared by the receiver config bank
package rxwk_pkg;
  // Wake-up criterion codes
  typedef enum logic [2:0] {
    CRIT_PATTERN = 3'h0,
    CRIT_RANDOM  = 3'h1,
    CRIT_EQUAL   = 3'h2,
    CRIT_SYNC    = 3'h3,
    CRIT_RSSI    = 3'h4,
    CRIT_SIGREC  = 3'h5,
    CRIT_NU6     = 3'h6,
    CRIT_NU7     = 3'h7
  } rxwk_crit_e;
  // IF path settings, bit 6 down to bit 0
  typedef struct packed {
    logic       sideband_select;
    logic [2:0] bandpass_width_select;
    logic       conversion_scheme_select;
    logic       if_buffer_enable;
    logic       ceramic_filter_count;
  } rxwk_ifcfg_s;
  // Wake-up control settings, bit 6 down to bit 0
  typedef struct packed {
    logic       parallel_wakeup_enable;
    logic       pattern_unit_select;
    logic       level_criterion_select;
    logic       ultrafast_fallback_enable;
    logic [2:0] wakeup_criterion_select;
  } rxwk_wuc_s;
  // Channel settings
  typedef struct packed {
    logic [1:0] search_mode;
    logic [1:0] external_processing_field;
  } rxwk_chcfg_s;
  // Settings as the wake-up search must apply them
  typedef struct packed {
    rxwk_crit_e criterion;
    logic       level_sel;
    logic       level_parallel;
    logic       ultrafast_fallback;
    logic       count_used;
    logic       count_in_chips;
    logic [6:0] count_limit;
  } rxwk_eff_s;
endpackage

//--- hw/rxwk_ahb_slave.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/10ps
`default_nettype none
`include "rxwk_regs.svh"
module rxwk_ahb_slave (
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write flag
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic        hready,    // Bus ready
  input  wire logic [31:0] rdata,     // Read mux value
  output logic             hreadyout, // Ready out
  output logic [31:0]      hrdata,    // Read data
  output logic             hresp,     // Always OKAY
  output logic             wr_stb,    // Write data phase
  output logic [7:0]       wr_idx,    // Write index
  output logic             rd_stb,    // Read capture cycle
  output logic [7:0]       rd_idx     // Read index
);
  logic       take;     // Address phase accepted
  logic       wr_pend_r; // Write data phase pending
  logic       rd_pend_r; // Read wait cycle pending
  logic [7:0] idx_r;    // Captured index

  assign take = hsel & htrans[1] & hready & (hsize == `RXWK_HSIZE_WORD);

  ////////////////////////////////////////////////////////////////////////
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 8'h00;
    end else begin
      // Pending flags live one cycle unless a new transfer follows
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      if (take) begin
        idx_r <= haddr[9:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready and read data; a read waits one cycle so it sees prior writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (take & ~hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rd_pend_r) begin
        hrdata <= rdata;
      end
    end
  end

  assign wr_stb = wr_pend_r;
  assign wr_idx = idx_r;
  assign rd_stb = rd_pend_r;
  assign rd_idx = idx_r;
endmodule
`default_nettype wire

//--- hw/rxwk_crit_map.sv
// Maps written wake-up settings to the settings applied by the search
`timescale 1ns/10ps
`default_nettype none
`include "rxwk_regs.svh"
module rxwk_crit_map (
  input  wire rxwk_pkg::rxwk_wuc_s   wuc,   // Wake-up control
  input  wire rxwk_pkg::rxwk_chcfg_s chcfg, // Channel settings
  input  wire logic [6:0]            count, // Bit/chip count
  output var  rxwk_pkg::rxwk_eff_s   eff    // Applied settings
);
  rxwk_pkg::rxwk_crit_e sel_c;  // Criterion as written
  rxwk_pkg::rxwk_crit_e crit_c; // Criterion after remap
  logic                 data_c; // Data criterion in use
  logic [1:0]           xp;     // External processing field

  assign xp = chcfg.external_processing_field;

  ////////////////////////////////////////////////////////////////////////
  // Criterion remap
  always_comb begin
    sel_c  = rxwk_pkg::rxwk_crit_e'(wuc.wakeup_criterion_select);
    crit_c = sel_c;
    if (xp == `RXWK_XP_SYNC && sel_c <= rxwk_pkg::CRIT_EQUAL) begin
      crit_c = rxwk_pkg::CRIT_SYNC;
    end else if (xp == `RXWK_XP_RSSI && sel_c == rxwk_pkg::CRIT_SIGREC) begin
      crit_c = rxwk_pkg::CRIT_RSSI;
    end
  end

  assign data_c = (crit_c <= rxwk_pkg::CRIT_SYNC);

  ////////////////////////////////////////////////////////////////////////
  // Applied settings
  always_comb begin
    eff                = '0;
    eff.criterion      = crit_c;
    // External RSSI processing forces RSSI as the level criterion
    eff.level_sel      = wuc.level_criterion_select
                         & (xp != `RXWK_XP_RSSI);
    eff.level_parallel = wuc.ultrafast_fallback_enable & data_c;
    // Ultrafast fall-back only in fast fall-back or permanent search
    eff.ultrafast_fallback = eff.level_parallel
                             & (chcfg.search_mode == `RXWK_SM_FFB
                                | chcfg.search_mode == `RXWK_SM_PWS);
    // Count is ignored for symbol sync and for level criteria
    eff.count_used     = data_c & (crit_c != rxwk_pkg::CRIT_SYNC);
    eff.count_in_chips = (crit_c == rxwk_pkg::CRIT_PATTERN)
                         & ~wuc.pattern_unit_select;
    eff.count_limit    = eff.count_used ? count : 7'h00;
  end
endmodule
`default_nettype wire

//--- hw/rxwk_top.sv
// Receiver IF path and wake-up configuration bank with AHB-Lite access
`timescale 1ns/10ps
`default_nettype none
`include "rxwk_regs.svh"
module rxwk_top (
  input  wire logic          hclk,      // Clock, 125 MHz
  input  wire logic          hresetn,   // Async reset, low
  input  wire logic          hsel,      // Slave select
  input  wire logic [31:0]   haddr,     // Byte address
  input  wire logic [1:0]    htrans,    // Transfer type
  input  wire logic          hwrite,    // Write flag
  input  wire logic [2:0]    hsize,     // Transfer size
  input  wire logic [31:0]   hwdata,    // Write data
  input  wire logic          hready,    // Bus ready
  output logic               hreadyout, // Ready out
  output logic [31:0]        hrdata,    // Read data
  output logic               hresp,     // Response, OKAY
  output rxwk_pkg::rxwk_ifcfg_s if_cfg, // IF path settings
  output rxwk_pkg::rxwk_wuc_s   wuc_cfg, // Wake-up settings
  output rxwk_pkg::rxwk_eff_s   eff,    // Applied wake-up settings
  output logic               irq        // Interrupt, high
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  wr_stb;   // Write data phase
  logic [7:0]            wr_idx;   // Write index
  logic                  rd_stb;   // Read capture cycle
  logic [7:0]            rd_idx;   // Read index
  logic [31:0]           rdata_c;  // Read mux
  logic                  wr_if;    // Write to IF register
  logic                  wr_wuc;   // Write to wake-up register
  logic                  wr_cnt;   // Write to count register
  logic                  wr_ch;    // Write to channel register
  logic                  wr_mask;  // Write to mask register
  logic [6:0]            cnt_r;    // Bit/chip count
  rxwk_pkg::rxwk_chcfg_s chcfg_r;  // Channel settings
  rxwk_pkg::rxwk_eff_s   eff_c;    // Applied settings, comb
  logic [2:0]            stat_r;   // Sticky status
  logic [2:0]            stat_nxt; // Next status
  logic [2:0]            mask_r;   // Interrupt mask
  logic [2:0]            mask_nxt; // Next mask
  logic [2:0]            ev_c;     // Events this cycle
  logic                  remap_c;  // Criterion remapped now
  logic                  remap_q;  // Remap state last cycle
  logic                  rd_clr;   // Status read clears

  ////////////////////////////////////////////////////////////////////////
  // Bus front end
  rxwk_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rdata     (rdata_c),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .wr_stb    (wr_stb),
    .wr_idx    (wr_idx),
    .rd_stb    (rd_stb),
    .rd_idx    (rd_idx)
  );

  // Write decode
  assign wr_if   = wr_stb & (wr_idx == `RXWK_IDX_IF);
  assign wr_wuc  = wr_stb & (wr_idx == `RXWK_IDX_WUC);
  assign wr_cnt  = wr_stb & (wr_idx == `RXWK_IDX_CNT);
  assign wr_ch   = wr_stb & (wr_idx == `RXWK_IDX_CHCFG);
  assign wr_mask = wr_stb & (wr_idx == `RXWK_IDX_MASK);

  ////////////////////////////////////////////////////////////////////////
  // IF path register; bit 7 is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      if_cfg <= `RXWK_RST_IF;
    end else if (wr_if) begin
      if_cfg <= hwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake-up control register; bit 7 is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wuc_cfg <= `RXWK_RST_WUC;
    end else if (wr_wuc) begin
      wuc_cfg <= hwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count and channel registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= `RXWK_RST_CNT;
      chcfg_r <= `RXWK_RST_CHCFG;
    end else begin
      if (wr_cnt) begin
        cnt_r <= hwdata[6:0];
      end
      if (wr_ch) begin
        chcfg_r <= hwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Criterion mapping, registered onto the output
  rxwk_crit_map u_map (
    .wuc   (wuc_cfg),
    .chcfg (chcfg_r),
    .count (cnt_r),
    .eff   (eff_c)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff <= '0;
    end else begin
      eff <= eff_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events: unused codes written, criterion remap starting
  assign remap_c = eff_c.criterion
                   != rxwk_pkg::rxwk_crit_e'(wuc_cfg.wakeup_criterion_select);
  always_comb begin
    ev_c                 = 3'h0;
    ev_c[`RXWK_ST_BW]    = wr_if & (hwdata[5:3] > `RXWK_BW_MAX);
    ev_c[`RXWK_ST_CRIT]  = wr_wuc & (hwdata[2:0] > `RXWK_CRIT_MAX);
    ev_c[`RXWK_ST_REMAP] = remap_c & ~remap_q;
  end

  // Status read clears; a same-cycle event still sets
  assign rd_clr   = rd_stb & (rd_idx == `RXWK_IDX_STAT);
  assign stat_nxt = (rd_clr ? 3'h0 : stat_r) | ev_c;
  assign mask_nxt = wr_mask ? hwdata[2:0] : mask_r;

  ////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r  <= `RXWK_RST_STAT;
      mask_r  <= `RXWK_RST_MASK;
      remap_q <= 1'b0;
      irq     <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      remap_q <= remap_c;
      irq     <= |(stat_nxt & mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_c = 32'h0000_0000;
    unique case (rd_idx)
      `RXWK_IDX_IF:    rdata_c[6:0]  = if_cfg;
      `RXWK_IDX_WUC:   rdata_c[6:0]  = wuc_cfg;
      `RXWK_IDX_CNT:   rdata_c[6:0]  = cnt_r;
      `RXWK_IDX_CHCFG: rdata_c[3:0]  = chcfg_r;
      `RXWK_IDX_STAT:  rdata_c[2:0]  = stat_r;
      `RXWK_IDX_MASK:  rdata_c[2:0]  = mask_r;
      `RXWK_IDX_EFF:   rdata_c[14:0] = eff;
      default:         rdata_c       = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_side_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_if |=> if_cfg.sideband_select == $past(hwdata[6]))
    else $error("sideband not taken from write");

  chk_bw_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_if |=> if_cfg.bandpass_width_select == $past(hwdata[5:3]))
    else $error("bandwidth not taken from write");

  chk_conv_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !wr_if |=> $stable(if_cfg.conversion_scheme_select))
    else $error("conversion changed without write");

  chk_buf_filter: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_if |=> {if_cfg.if_buffer_enable, if_cfg.ceramic_filter_count}
              == $past(hwdata[1:0]))
    else $error("buffer or filter bit wrong");

  chk_unit_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_wuc |=> wuc_cfg.pattern_unit_select == $past(hwdata[5]))
    else $error("pattern unit not taken");

  chk_level_sel: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wuc_cfg.level_criterion_select
     && chcfg_r.external_processing_field != `RXWK_XP_RSSI)
    |=> eff.level_sel)
    else $error("signal recognition not applied");

  chk_force_rssi: assert property (
    @(posedge hclk) disable iff (!hresetn)
    chcfg_r.external_processing_field == `RXWK_XP_RSSI
    |=> !eff.level_sel && eff.criterion != rxwk_pkg::CRIT_SIGREC)
    else $error("RSSI not forced");

  chk_par_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wuc_cfg.ultrafast_fallback_enable
     && eff_c.criterion <= rxwk_pkg::CRIT_SYNC)
    ##1 $stable(wuc_cfg) |-> eff.level_parallel)
    else $error("parallel level check missing");

  chk_ultrafast_fallback_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (eff_c.level_parallel && chcfg_r.search_mode == `RXWK_SM_COO)
    |=> eff.level_parallel && !eff.ultrafast_fallback)
    else $error("on-off mode wrong");

  chk_ultrafast_fallback_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (eff_c.level_parallel && chcfg_r.search_mode == `RXWK_SM_PWS)
    |=> eff.ultrafast_fallback)
    else $error("ultrafast fall-back missing");

  chk_crit_plain: assert property (
    @(posedge hclk) disable iff (!hresetn)
    chcfg_r.external_processing_field == 2'h0
    |=> eff.criterion == $past(wuc_cfg.wakeup_criterion_select))
    else $error("criterion not applied");

  chk_crit_remap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (chcfg_r.external_processing_field == `RXWK_XP_SYNC
     && wuc_cfg.wakeup_criterion_select <= 3'h2)
    |=> eff.criterion == rxwk_pkg::CRIT_SYNC)
    else $error("data criterion not remapped");

  chk_sync_count: assert property (
    @(posedge hclk) disable iff (!hresetn)
    eff.criterion == rxwk_pkg::CRIT_SYNC
    |-> !eff.count_used && eff.count_limit == 7'h00)
    else $error("count used in symbol sync");

  chk_chip_unit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    eff.count_in_chips |-> eff.criterion == rxwk_pkg::CRIT_PATTERN
                           && !$past(wuc_cfg.pattern_unit_select))
    else $error("chip unit outside pattern chip mode");

  chk_bit7_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rd_stb && (rd_idx == `RXWK_IDX_IF || rd_idx == `RXWK_IDX_WUC))
    |=> hrdata[31:7] == 25'h000_0000)
    else $error("unused bit reads nonzero");

  chk_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_stb |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  chk_bus_okay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0)
    else $error("response not okay");

  chk_stat_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|ev_c) |=> (stat_r & $past(ev_c)) == $past(ev_c))
    else $error("status event lost");

  chk_wuc_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !wr_wuc |=> $stable(wuc_cfg))
    else $error("wake-up settings changed without write");

  chk_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == |(stat_r & mask_r))
    else $error("interrupt out of step");
endmodule
`default_nettype wire

//--- verif/rxwk_top_test.sv
// Self-checking bench for the receiver IF and wake-up config bank
`timescale 1ns/10ps
`default_nettype none
`include "rxwk_regs.svh"
module rxwk_top_test;
  ////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic                  hclk;       // Bus clock
  logic                  hresetn;    // Async reset, low
  logic                  hsel;       // Slave select
  logic [31:0]           haddr;      // Byte address
  logic [1:0]            htrans;     // Transfer type
  logic                  hwrite;     // Write flag
  logic [2:0]            hsize;      // Transfer size
  logic [31:0]           hwdata;     // Write data
  wire logic             hready;     // Bus ready, from the slave
  logic                  hreadyout;  // Slave ready
  logic [31:0]           hrdata;     // Read data
  logic                  hresp;      // Response
  rxwk_pkg::rxwk_ifcfg_s if_cfg;     // IF path settings
  rxwk_pkg::rxwk_wuc_s   wuc_cfg;    // Wake-up settings
  rxwk_pkg::rxwk_eff_s   eff;        // Applied settings
  logic                  irq;        // Interrupt
  int                    n_mismatch; // Mismatch count
  int                    num_checks; // Comparison count
  logic [31:0]           rv;         // Read value
  logic [6:0]            w;          // Random wake-up value
  logic [3:0]            ch;         // Random channel value
  logic [6:0]            cnt;        // Random count value

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  rxwk_top rxwk_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .if_cfg(if_cfg), .wuc_cfg(wuc_cfg), .eff(eff),
    .irq(irq)
  );

  // Clock, 8 ns period
  always #4 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////
  // Report and compare
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares any result, zero extended to a word
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master
  // Waits for ready at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] d, input logic [2:0] sz,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    hsize  <= sz;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    cmp(hresp, 32'h0000_0000);
  endtask

  // Word write and word read
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, `RXWK_HSIZE_WORD, dummy);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] r);
    xfer(1'b0, idx, 32'h0000_0000, `RXWK_HSIZE_WORD, r);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expected applied settings from written values
  function automatic logic [14:0] exp_eff(logic [6:0] wv, logic [3:0] cv,
                                          logic [6:0] nv);
    logic [2:0] c;
    logic       ls;
    logic       lp;
    logic       uf;
    logic       used;
    logic       chips;
    c = wv[2:0];
    if (cv[1:0] == 2'h1 && c <= 3'h2) c = 3'h3;
    if (cv[1:0] == 2'h2 && c == 3'h5) c = 3'h4;
    ls = (cv[1:0] == 2'h2) ? 1'b0 : wv[4];
    lp = wv[3] && (c <= 3'h3);
    uf = lp && (cv[3:2] == 2'h1 || cv[3:2] == 2'h2);
    used = (c <= 3'h2);
    chips = (c == 3'h0) && !wv[5];
    return {c, ls, lp, uf, used, chips, used ? nv : 7'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `RXWK_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'h9b06));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values on the ports and over the bus
    cmp(if_cfg, 32'h0000_0020);
    cmp(wuc_cfg, 32'h0000_0004);
    cmp(irq, 32'h0000_0000);
    rd(`RXWK_IDX_IF, rv);
    cmp(rv, 32'h0000_0020);
    rd(`RXWK_IDX_WUC, rv);
    cmp(rv, 32'h0000_0004);
    cmp(eff, {17'h0, exp_eff(7'h04, 4'h0, 7'h00)});
    // Every criterion code under every processing field and unit
    for (int k = 0; k < 64; k++) begin
      // Both receive setups share one modulation, so bit 6 may be set
      w = 7'($urandom);
      w[2:0] = k[2:0];
      w[5] = k[5];
      ch = {2'({$urandom} % 3), k[4:3]};
      cnt = 7'($urandom);
      rv = $urandom;
      wr(`RXWK_IDX_IF, rv);
      // Register updates at the closing edge; look one edge later
      @(posedge hclk);
      cmp(if_cfg, {25'h0, rv[6:0]});
      wr(`RXWK_IDX_CHCFG, {28'h0, ch});
      wr(`RXWK_IDX_CNT, {25'h0, cnt});
      wr(`RXWK_IDX_WUC, {25'h0, w});
      repeat (2) @(posedge hclk);
      cmp(wuc_cfg, {25'h0, w});
      cmp(eff, {17'h0, exp_eff(w, ch, cnt)});
      rd(`RXWK_IDX_EFF, rv);
      cmp(rv, {17'h0, exp_eff(w, ch, cnt)});
    end
    // Quiet state, then clear pending status
    wr(`RXWK_IDX_CHCFG, 32'h0000_0000);
    wr(`RXWK_IDX_WUC, 32'h0000_0004);
    wr(`RXWK_IDX_IF, 32'h0000_0020);
    wr(`RXWK_IDX_MASK, 32'h0000_0000);
    rd(`RXWK_IDX_STAT, rv);
    // Masked event sets status but not the interrupt
    wr(`RXWK_IDX_IF, 32'h0000_0028);
    repeat (3) @(posedge hclk);
    cmp(irq, 32'h0000_0000);
    rd(`RXWK_IDX_STAT, rv);
    cmp(rv, 32'h0000_0001);
    rd(`RXWK_IDX_STAT, rv);
    cmp(rv, 32'h0000_0000);
    // Unmasked events raise it; the status read clears it
    wr(`RXWK_IDX_MASK, 32'h0000_0007);
    rd(`RXWK_IDX_MASK, rv);
    cmp(rv, 32'h0000_0007);
    wr(`RXWK_IDX_IF, 32'h0000_0038);
    repeat (3) @(posedge hclk);
    cmp(irq, 32'h0000_0001);
    rd(`RXWK_IDX_STAT, rv);
    cmp(rv, 32'h0000_0001);
    @(posedge hclk);
    cmp(irq, 32'h0000_0000);
    wr(`RXWK_IDX_WUC, 32'h0000_0006);
    repeat (3) @(posedge hclk);
    cmp(irq, 32'h0000_0001);
    rd(`RXWK_IDX_STAT, rv);
    cmp(rv, 32'h0000_0002);
    // Pattern code remapped under sync processing
    wr(`RXWK_IDX_CHCFG, 32'h0000_0001);
    wr(`RXWK_IDX_WUC, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    cmp(eff.criterion, 32'h0000_0003);
    rd(`RXWK_IDX_STAT, rv);
    cmp(rv, 32'h0000_0004);
    // Top bit, unmapped place and narrow transfer
    wr(`RXWK_IDX_IF, 32'hFFFF_FFFF);
    rd(`RXWK_IDX_IF, rv);
    cmp(rv, 32'h0000_007F);
    cmp(if_cfg, 32'h0000_007F);
    xfer(1'b1, `RXWK_IDX_IF, 32'h0000_0000, 3'h0, rv);
    @(posedge hclk);
    cmp(if_cfg, 32'h0000_007F);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, rv);
    cmp(rv, 32'h0000_0000);
    // Second reset in mid-run
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    cmp(if_cfg, 32'h0000_0020);
    cmp(wuc_cfg, 32'h0000_0004);
    cmp(irq, 32'h0000_0000);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(`RXWK_IDX_MASK, rv);
    cmp(rv, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
